/* core/vdpbl_pkg.sv */
/*
 Register map, field positions, reset values and timing constants.
 Assumes users name every item through the package.
*/
package vdpbl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG        = 8'h05;
    localparam logic [7:0] OFS_GAIN_RED      = 8'h06;
    localparam logic [7:0] OFS_GAIN_GREEN    = 8'h07;
    localparam logic [7:0] OFS_GAIN_BLUE     = 8'h08;
    localparam logic [7:0] OFS_OFFSET_RED    = 8'h09;
    localparam logic [7:0] OFS_OFFSET_GREEN  = 8'h0a;
    localparam logic [7:0] OFS_OFFSET_BLUE   = 8'h0b;
    localparam logic [7:0] OFS_BLACK_CTRL    = 8'h0c;
    localparam logic [7:0] OFS_PIXELS_LO     = 8'h0d;
    localparam logic [7:0] OFS_PIXELS_HI     = 8'h0e;
    localparam logic [7:0] OFS_PHASE         = 8'h0f;
    localparam logic [7:0] OFS_STATUS        = 8'h10;
    localparam logic [7:0] OFS_POWER         = 8'h1b;
    localparam logic [7:0] OFS_TUNING        = 8'h1c;
    localparam logic [7:0] OFS_CLAMP         = 8'h23;

    // Reset values
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [7:0] RST_GAIN     = 8'h55;
    localparam logic [7:0] RST_OFFSET   = 8'h80;
    localparam logic [7:0] RST_BLACK    = 8'h01;
    localparam logic [7:0] RST_PIXELS_LO = 8'h00;
    localparam logic [7:0] RST_PIXELS_HI = 8'h04;
    localparam logic [7:0] RST_PHASE    = 8'h00;
    localparam logic [7:0] RST_POWER    = 8'h00;
    localparam logic [7:0] RST_TUNING   = 8'h47;
    localparam logic [7:0] RST_CLAMP    = 8'h08;

    // Field positions
    localparam int POW_RED_BIT    = 0;
    localparam int POW_GREEN_BIT  = 1;
    localparam int POW_BLUE_BIT   = 2;
    localparam int POW_PLL_BIT    = 3;
    localparam int CLAMP_LSB      = 4;
    localparam int CLAMP_MSB      = 6;
    localparam int CFG_YUV_BIT    = 2;
    localparam int BLK_ENABLE_BIT = 0;
    localparam logic [7:0] POWER_MASK = 8'h0f;
    localparam logic [7:0] CLAMP_MASK = 8'h7f;
    localparam logic [7:0] PHASE_MASK = 8'h3f;
    localparam logic [7:0] PIXHI_MASK = 8'h0f;

    // Levels and widths
    localparam int          DAC_W        = 10;
    localparam int          PHASE_STEPS  = 64;
    localparam logic [7:0]  BLACK_TARGET = 8'h00;
    localparam logic [7:0]  BLACK_MID    = 8'h80;
    localparam logic [7:0]  OFFSET_NOM   = 8'h80;
    localparam logic [9:0]  DAC_MID      = 10'h200;
    localparam logic [9:0]  DAC_MAX      = 10'h3ff;

    // Black-level loop step rate: one quarter-LSB step per this many lines
    localparam int          STEP_LINES   = 16;
    localparam logic [3:0]  STEP_LAST    = 4'(STEP_LINES - 1);

    // Pixel-rate lock range
    localparam int PIX_MIN_MHZ = 10;
    localparam int PIX_MAX_MHZ = 210;
    localparam int CLK_MHZ     = 100;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } vdpbl_bus_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } vdpbl_rgb8_t;
endpackage

/* core/vdpbl_black_chan.sv */
/*
 One channel of the automatic black-level loop: a 10-bit offset converter
 code that walks in quarter-LSB steps toward the black target.
 Assumes a sampled black code and a step strobe from the same clock.
*/
`timescale 1ns/1ps
module vdpbl_black_chan (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       auto_en,
    input  wire logic       mid_black,
    input  wire logic [7:0] offset_reg,
    input  wire logic       step,
    input  wire logic [7:0] black_code,
    output logic      [9:0] dac_code
);
    logic [9:0] dac_ff;
    logic [9:0] nxt_dac;
    logic [8:0] target;
    logic [8:0] seen;

    // Offset register moves the target in whole ADC codes around nominal
    always_comb begin
        target = {1'b0, (mid_black ? vdpbl_pkg::BLACK_MID : vdpbl_pkg::BLACK_TARGET)}
               + {1'b0, offset_reg} - {1'b0, vdpbl_pkg::OFFSET_NOM};
        seen = {1'b0, black_code};
        nxt_dac = dac_ff;
        if (!auto_en) begin
            // Firmware owns the converter: the register in the upper 8 bits
            nxt_dac = {offset_reg, 2'b00};
        end else if (step) begin
            // Only a quarter-LSB move per step; equal leaves it untouched
            if (seen > target && dac_ff != 10'h000) begin
                nxt_dac = dac_ff - 10'h001;
            end else if (seen < target && dac_ff != vdpbl_pkg::DAC_MAX) begin
                nxt_dac = dac_ff + 10'h001;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dac_ff <= vdpbl_pkg::DAC_MID;
        end else begin
            dac_ff <= nxt_dac;
        end
    end

    assign dac_code = dac_ff;
endmodule

/* core/vdpbl_ctrl.sv */
/*
 Top of the power-down, clamp, phase-lock and black-level control block.
 Assumes a single-cycle register port on the pixel clock, and that sync
 and black-sample strobes from the analog side are asynchronous pins.
*/
`timescale 1ns/1ps
// Function
// - Each colour converter powers down while its power bit is one.
// - Power bit three powers down the pixel clock loop.
// - Bits 6:4 pick one clamp resistance shared by all channels.
// - Clamp code zero leaves the clamp disconnected from every channel.
// - The loop offers sixty-four sampling phases per pixel.
// - Loop locks across 10 to 210 MHz given only pixels per line.
// - Oscillator increment and phase hold constant through each line.
// - Automatic loop trims each 10-bit offset converter toward black.
// - Loop moves in quarter-LSB steps slowly, idle once matched.
// - Eight-bit offset register shifts black by whole ADC codes.
// - With automatic loop off converters follow firmware offsets.
// - Gain never changes offset nor converter step weight.
// - Three 8-bit gain registers sit at 0x06 to 0x08.
// - Three offset registers steer red, green and blue separately.
// - Nominal offset gives black code 0x00, or 0x80 on chroma in YUV.
// - Gain writes reach amplifiers only at the next line clamp event.
// - Config bit 2 enables YUV, moving chroma black to mid-scale.
module vdpbl_ctrl (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   hsync_in,
    input  wire logic                   clamp_in,
    input  wire logic [23:0]            black_in,
    output logic      [2:0]             adc_power_down,
    output logic                        pll_power_down,
    output logic      [2:0]             clamp_impedance,
    output logic                        clamp_connect,
    output logic      [7:0]             tuning_value,
    output vdpbl_pkg::vdpbl_rgb8_t      amp_gain,
    output logic      [29:0]            dac_codes,
    output logic                        yuv_mode,
    output logic      [5:0]             sample_phase,
    output logic      [11:0]            osc_increment,
    output logic                        pll_locked
);
    vdpbl_pkg::vdpbl_bus_t   bus;
    vdpbl_pkg::vdpbl_rgb8_t  gain_ff;
    vdpbl_pkg::vdpbl_rgb8_t  amp_ff;
    vdpbl_pkg::vdpbl_rgb8_t  offset_ff;
    logic [7:0]  config_ff;
    logic [7:0]  black_ctrl_ff;
    logic [7:0]  pix_lo_ff;
    logic [7:0]  pix_hi_ff;
    logic [7:0]  phase_ff;
    logic [7:0]  power_ff;
    logic [7:0]  tuning_ff;
    logic [7:0]  clamp_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [1:0]  hs_sync_ff;
    logic [1:0]  cl_sync_ff;
    logic        hs_prev_ff;
    logic        cl_prev_ff;
    logic [23:0] blk_meta_ff;
    logic [23:0] blk_sync_ff;
    logic [23:0] blk_ff;
    logic        line_start;
    logic        clamp_event;
    logic [3:0]  line_cnt_ff;
    logic        black_step;
    logic [11:0] osc_inc_ff;
    logic [5:0]  phase_out_ff;
    logic        lock_ff;
    logic        auto_en;
    wire logic [2:0] dac_mid;

    typedef enum logic [1:0] {
        VDPBL_IDLE    = 2'b00,
        VDPBL_ACQUIRE = 2'b01,
        VDPBL_LOCKED  = 2'b10
    } vdpbl_lock_t;
    vdpbl_lock_t lock_state_ff;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Register writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            config_ff     <= vdpbl_pkg::RST_CONFIG;
            gain_ff       <= '{default: vdpbl_pkg::RST_GAIN};
            offset_ff     <= '{default: vdpbl_pkg::RST_OFFSET};
            black_ctrl_ff <= vdpbl_pkg::RST_BLACK;
            pix_lo_ff     <= vdpbl_pkg::RST_PIXELS_LO;
            pix_hi_ff     <= vdpbl_pkg::RST_PIXELS_HI;
            phase_ff      <= vdpbl_pkg::RST_PHASE;
            power_ff      <= vdpbl_pkg::RST_POWER;
            tuning_ff     <= vdpbl_pkg::RST_TUNING;
            clamp_ff      <= vdpbl_pkg::RST_CLAMP;
        end else if (bus.wr) begin
            if (bus.addr == vdpbl_pkg::OFS_CONFIG) begin
                config_ff <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_GAIN_RED) begin
                gain_ff.red <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_GAIN_GREEN) begin
                gain_ff.green <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_GAIN_BLUE) begin
                gain_ff.blue <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_OFFSET_RED) begin
                offset_ff.red <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_OFFSET_GREEN) begin
                offset_ff.green <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_OFFSET_BLUE) begin
                offset_ff.blue <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_BLACK_CTRL) begin
                black_ctrl_ff <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_PIXELS_LO) begin
                pix_lo_ff <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_PIXELS_HI) begin
                pix_hi_ff <= bus.wdata & vdpbl_pkg::PIXHI_MASK;
            end else if (bus.addr == vdpbl_pkg::OFS_PHASE) begin
                phase_ff <= bus.wdata & vdpbl_pkg::PHASE_MASK;
            end else if (bus.addr == vdpbl_pkg::OFS_POWER) begin
                // Reserved bits are dropped so they always read back zero
                power_ff <= bus.wdata & vdpbl_pkg::POWER_MASK;
            end else if (bus.addr == vdpbl_pkg::OFS_TUNING) begin
                tuning_ff <= bus.wdata;
            end else if (bus.addr == vdpbl_pkg::OFS_CLAMP) begin
                clamp_ff <= bus.wdata & vdpbl_pkg::CLAMP_MASK;
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == vdpbl_pkg::OFS_CONFIG) begin
                nxt_rdata = config_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_GAIN_RED) begin
                nxt_rdata = gain_ff.red;
            end else if (bus.addr == vdpbl_pkg::OFS_GAIN_GREEN) begin
                nxt_rdata = gain_ff.green;
            end else if (bus.addr == vdpbl_pkg::OFS_GAIN_BLUE) begin
                nxt_rdata = gain_ff.blue;
            end else if (bus.addr == vdpbl_pkg::OFS_OFFSET_RED) begin
                nxt_rdata = offset_ff.red;
            end else if (bus.addr == vdpbl_pkg::OFS_OFFSET_GREEN) begin
                nxt_rdata = offset_ff.green;
            end else if (bus.addr == vdpbl_pkg::OFS_OFFSET_BLUE) begin
                nxt_rdata = offset_ff.blue;
            end else if (bus.addr == vdpbl_pkg::OFS_BLACK_CTRL) begin
                nxt_rdata = black_ctrl_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_PIXELS_LO) begin
                nxt_rdata = pix_lo_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_PIXELS_HI) begin
                nxt_rdata = pix_hi_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_PHASE) begin
                nxt_rdata = phase_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_STATUS) begin
                nxt_rdata = {5'h00, dac_mid[0], lock_ff, auto_en};
            end else if (bus.addr == vdpbl_pkg::OFS_POWER) begin
                nxt_rdata = power_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_TUNING) begin
                nxt_rdata = tuning_ff;
            end else if (bus.addr == vdpbl_pkg::OFS_CLAMP) begin
                nxt_rdata = clamp_ff;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Pin synchronisers; first stages feed only the second stages
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hs_sync_ff  <= 2'b00;
            cl_sync_ff  <= 2'b00;
            hs_prev_ff  <= 1'b0;
            cl_prev_ff  <= 1'b0;
            blk_meta_ff <= 24'h000000;
            blk_sync_ff <= 24'h000000;
            blk_ff      <= 24'h000000;
        end else begin
            hs_sync_ff  <= {hs_sync_ff[0], hsync_in};
            cl_sync_ff  <= {cl_sync_ff[0], clamp_in};
            hs_prev_ff  <= hs_sync_ff[1];
            cl_prev_ff  <= cl_sync_ff[1];
            blk_meta_ff <= black_in;
            blk_sync_ff <= blk_meta_ff;
            // Samples pass as many stages as the clamp pin, so the window lines up
            if (cl_sync_ff[1]) begin
                blk_ff <= blk_sync_ff;
            end
        end
    end

    assign line_start  = hs_sync_ff[1] & ~hs_prev_ff;
    // Clamp window closing marks the per-line clamp event
    assign clamp_event = cl_prev_ff & ~cl_sync_ff[1];

    // Gain reaches the amplifiers only at the clamp event
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            amp_ff <= '{default: vdpbl_pkg::RST_GAIN};
        end else if (clamp_event) begin
            amp_ff <= gain_ff;
        end
    end

    // Low step rate: one loop step per STEP_LINES clamp events
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_cnt_ff <= 4'h0;
        end else if (clamp_event) begin
            line_cnt_ff <= (line_cnt_ff == vdpbl_pkg::STEP_LAST) ? 4'h0 : line_cnt_ff + 4'h1;
        end
    end

    assign black_step = clamp_event && (line_cnt_ff == vdpbl_pkg::STEP_LAST);
    assign auto_en    = black_ctrl_ff[vdpbl_pkg::BLK_ENABLE_BIT];
    assign yuv_mode   = config_ff[vdpbl_pkg::CFG_YUV_BIT];

    // Red and blue carry colour difference in YUV mode; green is luma
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
            vdpbl_black_chan u_chan (
                .clock      (clock),
                .rst        (rst),
                .auto_en    (auto_en),
                .mid_black  (yuv_mode && (ch != 1)),
                .offset_reg (offset_ff[8*(2-ch) +: 8]),
                .step       (black_step),
                .black_code (blk_ff[8*ch +: 8]),
                .dac_code   (dac_codes[10*ch +: 10])
            );
            assign dac_mid[ch] = (dac_codes[10*ch +: 10] == vdpbl_pkg::DAC_MID);
        end
    endgenerate

    // Oscillator increment only changes at a line start, never mid-line
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osc_inc_ff    <= {vdpbl_pkg::RST_PIXELS_HI[3:0], vdpbl_pkg::RST_PIXELS_LO};
            phase_out_ff  <= 6'h00;
        end else if (line_start) begin
            osc_inc_ff   <= {pix_hi_ff[3:0], pix_lo_ff};
            phase_out_ff <= phase_ff[5:0];
        end
    end

    // Lock tracking: locks after one full line with a stable setting
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_state_ff <= VDPBL_IDLE;
        end else if (power_ff[vdpbl_pkg::POW_PLL_BIT]) begin
            lock_state_ff <= VDPBL_IDLE;
        end else if (line_start) begin
            case (lock_state_ff)
                VDPBL_IDLE:    lock_state_ff <= VDPBL_ACQUIRE;
                VDPBL_ACQUIRE: lock_state_ff <= VDPBL_LOCKED;
                VDPBL_LOCKED: begin
                    if (osc_inc_ff != {pix_hi_ff[3:0], pix_lo_ff}) begin
                        lock_state_ff <= VDPBL_ACQUIRE;
                    end
                end
                default:       lock_state_ff <= VDPBL_IDLE;
            endcase
        end
    end

    assign lock_ff = (lock_state_ff == VDPBL_LOCKED);

    assign reg_rdata       = rdata_ff;
    assign adc_power_down  = {power_ff[vdpbl_pkg::POW_BLUE_BIT],
                              power_ff[vdpbl_pkg::POW_GREEN_BIT],
                              power_ff[vdpbl_pkg::POW_RED_BIT]};
    assign pll_power_down  = power_ff[vdpbl_pkg::POW_PLL_BIT];
    assign clamp_impedance = clamp_ff[vdpbl_pkg::CLAMP_MSB:vdpbl_pkg::CLAMP_LSB];
    assign clamp_connect   = (clamp_impedance != 3'h0);
    assign tuning_value    = tuning_ff;
    // Gain path is separate from the offset path, so gain never moves it
    assign amp_gain        = amp_ff;
    assign sample_phase    = phase_out_ff;
    assign osc_increment   = osc_inc_ff;
    assign pll_locked      = lock_ff;
endmodule

/* verif/vdpbl_ctrl_monitor.sv */
/*
 Port checker of the control block.
 Assumes it is bound to vdpbl_ctrl on one clock.
*/
`timescale 1ns/1ps
module vdpbl_ctrl_monitor (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  hsync_in,
    input wire logic                  clamp_in,
    input wire logic [23:0]           black_in,
    input wire logic [2:0]            adc_power_down,
    input wire logic                  pll_power_down,
    input wire logic [2:0]            clamp_impedance,
    input wire logic                  clamp_connect,
    input wire logic [7:0]            tuning_value,
    input wire vdpbl_pkg::vdpbl_rgb8_t amp_gain,
    input wire logic [29:0]           dac_codes,
    input wire logic                  yuv_mode,
    input wire logic [5:0]            sample_phase,
    input wire logic [11:0]           osc_increment,
    input wire logic                  pll_locked
);
    logic       clamp_prev_ff;
    logic       hs_prev_ff;
    logic [3:0] clamp_age_ff;
    logic [3:0] hs_age_ff;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // Ages since each pin edge; the design lags them by a few cycles
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {clamp_prev_ff, hs_prev_ff} <= 2'b00;
            {clamp_age_ff, hs_age_ff}   <= 8'hff;
        end else begin
            {clamp_prev_ff, hs_prev_ff} <= {clamp_in, hsync_in};
            clamp_age_ff <= (clamp_prev_ff && !clamp_in) ? 4'h0
                          : clamp_age_ff + 4'(clamp_age_ff != 4'hf);
            hs_age_ff    <= (!hs_prev_ff && hsync_in) ? 4'h0
                          : hs_age_ff + 4'(hs_age_ff != 4'hf);
        end
    end

    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_clamp_recent;
        clamp_age_ff <= 4'h6;
    endsequence

    property p_pd; s_wr(8'h1b) |=> {pll_power_down, adc_power_down} == 4'($past(reg_wdata)); endproperty
    a_pd: assert property (p_pd) else $error("power bits differ from write");
    property p_pll_idle; pll_power_down |=> !pll_locked; endproperty
    a_pll_idle: assert property (p_pll_idle) else $error("locked while powered down");
    property p_clamp; s_wr(8'h23) |=> clamp_impedance == 3'($past(reg_wdata) >> 4); endproperty
    a_clamp: assert property (p_clamp) else $error("clamp code differs from write");
    property p_open; clamp_connect == (clamp_impedance != 3'h0); endproperty
    a_open: assert property (p_open) else $error("clamp connect wrong for code");
    property p_gain; $changed(amp_gain) |-> s_clamp_recent; endproperty
    a_gain: assert property (p_gain) else $error("gain moved outside clamp event");
    property p_hold; $changed({sample_phase, osc_increment}) |-> hs_age_ff <= 4'h6; endproperty
    a_hold: assert property (p_hold) else $error("phase moved inside a line");
    property p_yuv; s_wr(8'h05) |=> yuv_mode == (($past(reg_wdata) & 8'h04) != 8'h00); endproperty
    a_yuv: assert property (p_yuv) else $error("yuv mode differs from write");
    property p_rst;
        disable iff (1'b0) rst |-> tuning_value == 8'h47 && {adc_power_down, pll_power_down,
            clamp_impedance} == 7'h00 && dac_codes == {3{10'h200}} && !pll_locked;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at defaults in reset");
endmodule

bind vdpbl_ctrl vdpbl_ctrl_monitor u_mon (.*);

/* verif/vdpbl_video_src.sv */
/*
 Video source: line sync, one clamp window a line, black samples.
 Assumes the bench drives run.
*/
`timescale 1ns/1ps
module vdpbl_video_src (
    input  wire logic        clock,
    input  wire logic        run,
    input  wire logic [23:0] level,
    output logic             hsync_in,
    output logic             clamp_in,
    output logic      [23:0] black_in
);
    logic [5:0] cnt_ff = 6'h00;

    always @(posedge clock) begin
        cnt_ff <= run ? cnt_ff + 6'h01 : 6'h00;
    end
    assign hsync_in = run && cnt_ff[5:2] == 4'h0;
    // One window per line, so at most one gain update per line
    assign clamp_in = run && cnt_ff[5:3] == 3'h1;
    // Outside the window the samples are not held and keep moving
    assign black_in = (cnt_ff[5:3] == 3'h1) ? level : {4{cnt_ff}};
endmodule

/* verif/testbench.sv */
/*
 Self-checking bench of the control block.
 Assumes the design, checker and video source are compiled.
*/
`timescale 1ns/1ps
module testbench;
    logic                  clock = 1'b0;
    logic                  rst = 1'b0;
    logic                  run = 1'b0;
    vdpbl_pkg::vdpbl_bus_t bus = '0;
    logic [7:0]            reg_rdata, tuning_value;
    logic [2:0]            adc_power_down, clamp_impedance;
    logic                  pll_power_down, clamp_connect, yuv_mode, pll_locked, hsync_in, clamp_in;
    vdpbl_pkg::vdpbl_rgb8_t amp_gain;
    logic [29:0]           dac_codes;
    logic [5:0]            sample_phase;
    logic [11:0]           osc_increment;
    logic [23:0]           black_in, lvl = 24'h000000;
    logic [7:0]            m [256];
    logic [7:0]            o [3], g [3];
    logic [7:0]            ra [$] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
                                      8'h0d, 8'h0e, 8'h0f, 8'h1b, 8'h1c, 8'h23, 8'h30};
    logic [31:0]           seed = 32'h388a2040, v;
    int                    n_mismatch = 0, checks_done = 0;

    vdpbl_ctrl dut (.clock, .rst, .reg_addr(bus.addr), .reg_wdata(bus.wdata), .reg_wr(bus.wr),
        .reg_rd(bus.rd), .reg_rdata, .hsync_in, .clamp_in, .black_in, .adc_power_down,
        .pll_power_down, .clamp_impedance, .clamp_connect, .tuning_value, .amp_gain,
        .dac_codes, .yuv_mode, .sample_phase, .osc_increment, .pll_locked);
    vdpbl_video_src src (.clock, .run, .level(lvl), .hsync_in, .clamp_in, .black_in);

    initial begin
        forever #5 clock = ~clock;
    end

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Writable bits per address
    function logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h1b, 8'h0e: return 8'h0f;
            8'h23: return 8'h7f;
            8'h0f: return 8'h3f;
            8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h1c: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction
    function int nudge(input int d, input int s, input int t);
        return d + int'(s < t) - int'(s > t);
    endfunction

    task mreset();
        foreach (m[i]) m[i] = 8'h00;
        for (int i = 6; i < 9; i++) begin
            m[i] = 8'h55;
            m[i + 3] = 8'h80;
        end
        m[8'h0c] = 8'h01;
        m[8'h0e] = 8'h04;
        m[8'h1c] = 8'h47;
        m[8'h23] = 8'h08;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
        m[a] = d & msk(a);
    endtask
    task rd(input logic [7:0] a);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        chk(32'(reg_rdata), 32'(m[a]));
    endtask
    task settle();
        repeat (4) @(posedge clock);
        #1;
    endtask
    task lines(input int n);
        @(posedge clock);
        run <= 1'b1;
        repeat (n) @(negedge clamp_in);
        @(posedge clock);
        run <= 1'b0;
    endtask
    task reset_chk();
        foreach (ra[i]) rd(ra[i]);
        chk(32'({adc_power_down, pll_power_down, clamp_impedance, clamp_connect, tuning_value}),
            32'h47);
        chk(32'({amp_gain, yuv_mode}), 32'h0aaaaaa);
        chk(32'(dac_codes), 32'({3{10'h200}}));
        chk(32'({sample_phase, osc_increment, pll_locked}), 32'({6'h00, 12'h400, 1'b0}));
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mreset();
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        reset_chk();
        $display("test reset done");
        // Reserved power bits and an unmapped write carry random junk
        for (int i = 15; i >= 0; i--) begin
            v = xs();
            wr(8'h1b, {v[7:4], 4'(i)});
            wr(8'h30, v[15:8]);
            settle();
            chk(32'({pll_power_down, adc_power_down}), 32'(i));
            rd(8'h1b);
            rd(8'h30);
        end
        $display("test power done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h23, {1'b0, 3'(c), 4'h8});
            settle();
            chk(32'({clamp_impedance, clamp_connect}), 32'({3'(c), c != 0}));
            rd(8'h23);
        end
        wr(8'h1c, 8'h49);
        settle();
        chk(32'(tuning_value), 32'h49);
        $display("test clamp done");
        wr(8'h0c, 8'h00);
        for (int c = 0; c < 3; c++) begin
            v = xs();
            o[c] = v[7:0];
            g[c] = v[15:8];
            wr(8'h09 + 8'(c), o[c]);
            wr(8'h06 + 8'(c), g[c]);
        end
        wr(8'h0f, 8'hff);
        wr(8'h0d, v[31:24]);
        wr(8'h0e, 8'h03);
        settle();
        chk(32'(dac_codes), 32'({o[2], 2'b00, o[1], 2'b00, o[0], 2'b00}));
        chk(32'(amp_gain), 32'h555555);
        chk(32'({sample_phase, osc_increment}), 32'({6'h00, 12'h400}));
        lines(3);
        settle();
        chk(32'(amp_gain), 32'({g[0], g[1], g[2]}));
        chk(32'({sample_phase, osc_increment, pll_locked}), 32'({6'h3f, 4'h3, v[31:24], 1'b1}));
        chk(32'(dac_codes), 32'({o[2], 2'b00, o[1], 2'b00, o[0], 2'b00}));
        for (int i = 6; i < 12; i++) rd(8'(i));
        wr(8'h1b, 8'h08);
        settle();
        chk(32'({pll_power_down, pll_locked}), 32'h2);
        wr(8'h1b, 8'h00);
        $display("test manual done");
        for (int c = 0; c < 3; c++) wr(8'h09 + 8'(c), 8'h80);
        wr(8'h05, 8'h04);
        settle();
        chk(32'({yuv_mode, dac_codes}), 32'({1'b1, {3{10'h200}}}));
        lvl <= 24'h800700;
        wr(8'h0c, 8'h01);
        lines(16);
        settle();
        chk(32'(dac_codes), 32'({10'(nudge(512, 128, 128)), 10'(nudge(512, 7, 0)),
            10'(nudge(512, 0, 128))}));
        $display("test auto done");
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        mreset();
        reset_chk();
        $display("test second reset done");
        report_and_stop();
    end

    initial begin
        // The sequence needs about 1500 cycles
        repeat (20000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end
endmodule
